/* File: hdl/tpa_trace_accumulator.v */
// Three-trace pixel accumulator with APB registers, sample stream input and trace read port.
// Assumes one sample source giving a start flag on each sweep's first sample, and a reader polling pixels.
//
// How it works
// - Each trace stores 625 pixels; 2^spp consecutive samples merge into one pixel.
// - Detectors give largest, smallest, last sample, mean power or mean value per pixel.
// - Dual-extreme detector stores both largest and smallest level of each pixel.
// - One mode code per trace, so exactly one mode is active.
// - Reset puts trace 1 in overwrite, traces 2 and 3 blanked.
// - Overwrite replaces pixels each sweep; automatic detector means dual-extreme.
// - Peak hold keeps the larger value and forces the upper-extreme detector.
// - Averaging takes any detector; automatic choice means instant detector.
// - Sweep total zero averages as nine old plus one new over ten.
// - With total above one, sweep one stored raw, sweep n stores mean of n.
// - Past total N in continuous sweeping, average is (N-1) old plus new over N.
// - Start runs the total number of sweeps, one sweep when the total is zero, then stops; index readable.
// - Sweep total accepts 0 to 30000; larger writes clamp to 30000.
// - Sweep total one takes each sweep unchanged in hold and averaging modes.
// - Freeze stops writes to the trace but keeps presenting stored contents.
// - Settings changed while frozen raise a mismatch flag for that trace.
// - Stored values are mapped through reference and range at readout, so frozen data rescales.
// - Blanked trace gives no valid output to the reader.
// - Averaging uses linear values or log levels; switching scale restarts measurement.
// - Floor hold keeps the smaller value and forces the lower-extreme detector.
// - Config writes clear hold traces unless the hold-reset inhibit is set; inhibit resets clear.
//
// Local design decisions: the register addresses and register access over APB.
`include "tpa_defs.vh"
`timescale 1ns/1ps
module tpa_trace_accumulator #(
    parameter PIXELS = 625,
    parameter DW = 16,
    parameter AW = 11,
    parameter SPPW = 3,
    parameter [14:0] MAX_COUNT = 15'd30000
) (
    input wire clk_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire smp_valid_i,
    output wire smp_ready_o,
    input wire smp_sweep_start_i,
    input wire [DW-1:0] smp_level_i,
    input wire [DW-1:0] smp_pow_i,
    input wire rd_en_i,
    input wire [1:0] rd_trace_i,
    input wire [9:0] rd_pix_i,
    output reg rd_valid_o,
    output reg [DW-1:0] rd_hi_o,
    output reg [DW-1:0] rd_lo_o,
    output wire sweep_busy_o
);
    localparam SW_IDLE = 3'b001;
    localparam SW_WAIT = 3'b010;
    localparam SW_RUN = 3'b100;
    localparam SUMW = DW + (1 << SPPW);

    reg [DW-1:0] mem_hi [0:3*PIXELS-1];
    reg [DW-1:0] mem_lo [0:3*PIXELS-1];
    reg [2:0] mode_reg [0:2];
    reg [2:0] det_reg [0:2];
    reg [2:0] fresh_reg;
    reg [2:0] arm_reg;
    reg [2:0] mism_reg;
    reg [14:0] count_reg;
    reg cont_reg;
    reg scale_reg;
    reg inhibit_reg;
    reg [SPPW-1:0] spp_reg;
    reg [DW-1:0] ref_reg;
    reg [7:0] gain_reg;
    reg [2:0] sw_reg;
    reg single_reg;
    reg [14:0] idx_reg;
    reg [2:0] proc_reg;
    reg [9:0] pix_reg;
    reg [(1<<SPPW)-1:0] cnt_reg;
    reg [DW-1:0] acc_hi_reg;
    reg [DW-1:0] acc_lo_reg;
    reg [SUMW-1:0] acc_sum_reg;
    reg [SUMW-1:0] acc_psum_reg;
    reg [DW-1:0] pix_hi_reg;
    reg [DW-1:0] pix_lo_reg;
    reg [DW-1:0] pix_last_reg;
    reg [DW-1:0] pix_mean_reg;
    reg [DW-1:0] pix_rms_reg;

    wire setup = psel_i & ~penable_i;
    wire wr = psel_i & penable_i & pwrite_i;
    wire mapped = (paddr_i == `TPA_OFF_TRACE0) | (paddr_i == `TPA_OFF_TRACE1) | (paddr_i == `TPA_OFF_TRACE2) |
                  (paddr_i == `TPA_OFF_CFG) | (paddr_i == `TPA_OFF_CMD) | (paddr_i == `TPA_OFF_STATUS) |
                  (paddr_i == `TPA_OFF_DISPLAY);
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    wire wr_cfg = wr & (paddr_i == `TPA_OFF_CFG);
    wire wr_dsp = wr & (paddr_i == `TPA_OFF_DISPLAY);
    wire wr_start = wr & (paddr_i == `TPA_OFF_CMD) & pwdata_i[`TPA_CMD_START];
    wire [2:0] wr_tr = {wr & (paddr_i == `TPA_OFF_TRACE2), wr & (paddr_i == `TPA_OFF_TRACE1),
                        wr & (paddr_i == `TPA_OFF_TRACE0)};
    wire [2:0] new_mode = pwdata_i[`TPA_TR_MODE_MSB:`TPA_TR_MODE_LSB];
    wire [14:0] new_cnt = (pwdata_i[`TPA_CFG_CNT_MSB:`TPA_CFG_CNT_LSB] > MAX_COUNT) ? MAX_COUNT :
                          pwdata_i[`TPA_CFG_CNT_MSB:`TPA_CFG_CNT_LSB];
    wire scale_flip = wr_cfg & (pwdata_i[`TPA_CFG_SCALE] != scale_reg);
    wire restart = scale_flip | wr_start;

    // Sample stream: new samples wait while a closed pixel is being written to the traces
    assign smp_ready_o = (proc_reg == 3'b000);
    wire first = (sw_reg == SW_WAIT) & smp_valid_i & smp_sweep_start_i;
    wire take = smp_valid_i & smp_ready_o & ((sw_reg == SW_RUN) | first);
    wire [DW-1:0] wv = scale_reg ? smp_pow_i : smp_level_i;
    wire [(1<<SPPW)-1:0] last_cnt = ({{((1<<SPPW)-1){1'b0}}, 1'b1} << spp_reg) - 1'b1;
    wire pix_close = take & (cnt_reg == last_cnt);
    wire [DW-1:0] hi_n = (cnt_reg == 0 || wv > acc_hi_reg) ? wv : acc_hi_reg;
    wire [DW-1:0] lo_n = (cnt_reg == 0 || wv < acc_lo_reg) ? wv : acc_lo_reg;
    wire [SUMW-1:0] sum_n = ((cnt_reg == 0) ? {SUMW{1'b0}} : acc_sum_reg) + {{(SUMW-DW){1'b0}}, wv};
    wire [SUMW-1:0] psum_n = ((cnt_reg == 0) ? {SUMW{1'b0}} : acc_psum_reg) + {{(SUMW-DW){1'b0}}, smp_pow_i};
    wire [SUMW-1:0] mean_w = sum_n >> spp_reg;
    wire [SUMW-1:0] rms_w = psum_n >> spp_reg;

    wire [1:0] tsel = proc_reg[2] ? 2'd2 : (proc_reg[1] ? 2'd1 : 2'd0);
    wire sweep_end = proc_reg[2] & (pix_reg == PIXELS - 1);
    wire [31:0] waddr_w = tsel * PIXELS + pix_reg;
    wire [AW-1:0] waddr = waddr_w[AW-1:0];
    wire [2:0] cur_mode = mode_reg[tsel];
    wire [15:0] weight = (count_reg == 0) ? `TPA_RUN_WEIGHT : {1'b0, idx_reg};
    assign sweep_busy_o = (sw_reg != SW_IDLE);

    function [2:0] eff_det;
        input [2:0] m;
        input [2:0] d;
        begin
            if (m == `TPA_MODE_PEAK) begin
                eff_det = `TPA_DET_UPPER;
            end else if (m == `TPA_MODE_FLOOR) begin
                eff_det = `TPA_DET_LOWER;
            end else if (d == `TPA_DET_AUTO || d > `TPA_DET_DUAL) begin
                eff_det = (m == `TPA_MODE_AVG) ? `TPA_DET_INSTANT : `TPA_DET_DUAL;
            end else begin
                eff_det = d;
            end
        end
    endfunction

    // Rounded weighted mean; k of one or zero never reaches here
    function [DW-1:0] avgf;
        input [DW-1:0] o;
        input [DW-1:0] n;
        input [15:0] k;
        reg [DW+16:0] num;
        reg [DW+16:0] q;
        begin
            num = o * (k - 16'd1) + n + (k >> 1);
            q = num / k;
            avgf = q[DW-1:0];
        end
    endfunction

    // Display mapping keeps stored data absolute, so ref or range edits rescale instead of discarding
    function [DW-1:0] dmap;
        input [DW-1:0] v;
        input [DW-1:0] r;
        input [7:0] g;
        reg signed [DW:0] d;
        reg signed [DW+9:0] p;
        begin
            d = $signed({1'b0, v}) - $signed({1'b0, r});
            p = (d * $signed({1'b0, g})) >>> `TPA_GAIN_SHIFT;
            if (p > $signed({{10{1'b0}}, {(DW-1){1'b1}}})) begin
                dmap = {1'b0, {(DW-1){1'b1}}};
            end else if (p < -$signed({{10{1'b0}}, 1'b1, {(DW-1){1'b0}}})) begin
                dmap = {1'b1, {(DW-1){1'b0}}};
            end else begin
                dmap = p[DW-1:0];
            end
        end
    endfunction

    reg [2:0] ed;
    reg [DW-1:0] dv_hi;
    reg [DW-1:0] dv_lo;
    reg [DW-1:0] old_hi;
    reg [DW-1:0] old_lo;
    reg [DW-1:0] wr_hi;
    reg [DW-1:0] wr_lo;
    reg we;
    reg raw;
    always @* begin
        ed = eff_det(cur_mode, det_reg[tsel]);
        old_hi = mem_hi[waddr];
        old_lo = mem_lo[waddr];
        case (ed)
            `TPA_DET_UPPER: dv_hi = pix_hi_reg;
            `TPA_DET_LOWER: dv_hi = pix_lo_reg;
            `TPA_DET_INSTANT: dv_hi = pix_last_reg;
            `TPA_DET_RMS: dv_hi = pix_rms_reg;
            `TPA_DET_MEAN: dv_hi = pix_mean_reg;
            default: dv_hi = pix_hi_reg;
        endcase
        dv_lo = (ed == `TPA_DET_DUAL) ? pix_lo_reg : dv_hi;
        raw = fresh_reg[tsel] | (count_reg == 15'd1) | (weight < 16'd2);
        we = (proc_reg != 3'b000) & (cur_mode != `TPA_MODE_FREEZE) & (cur_mode != `TPA_MODE_BLANK);
        wr_hi = dv_hi;
        wr_lo = dv_lo;
        case (cur_mode)
            `TPA_MODE_PEAK: begin
                if (!raw) begin
                    wr_hi = (dv_hi > old_hi) ? dv_hi : old_hi;
                    wr_lo = (dv_lo > old_lo) ? dv_lo : old_lo;
                end
            end
            `TPA_MODE_FLOOR: begin
                if (!raw) begin
                    wr_hi = (dv_hi < old_hi) ? dv_hi : old_hi;
                    wr_lo = (dv_lo < old_lo) ? dv_lo : old_lo;
                end
            end
            `TPA_MODE_AVG: begin
                if (!raw) begin
                    wr_hi = avgf(old_hi, dv_hi, weight);
                    wr_lo = avgf(old_lo, dv_lo, weight);
                end
            end
            default: begin
                wr_hi = dv_hi;
                wr_lo = dv_lo;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (we) begin
            mem_hi[waddr] <= wr_hi;
            mem_lo[waddr] <= wr_lo;
        end
    end

    // Pixel accumulation and per-trace write sequencing
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_reg <= {(1<<SPPW){1'b0}};
            acc_hi_reg <= {DW{1'b0}};
            acc_lo_reg <= {DW{1'b0}};
            acc_sum_reg <= {SUMW{1'b0}};
            acc_psum_reg <= {SUMW{1'b0}};
            pix_hi_reg <= {DW{1'b0}};
            pix_lo_reg <= {DW{1'b0}};
            pix_last_reg <= {DW{1'b0}};
            pix_mean_reg <= {DW{1'b0}};
            pix_rms_reg <= {DW{1'b0}};
            proc_reg <= 3'b000;
            pix_reg <= 10'h000;
        end else begin
            if (first) begin
                pix_reg <= 10'h000;
            end else if (proc_reg[2]) begin
                pix_reg <= sweep_end ? 10'h000 : pix_reg + 10'h001;
            end
            proc_reg <= pix_close ? 3'b001 : {proc_reg[1:0], 1'b0};
            if (take) begin
                acc_hi_reg <= hi_n;
                acc_lo_reg <= lo_n;
                acc_sum_reg <= sum_n;
                acc_psum_reg <= psum_n;
                cnt_reg <= pix_close ? {(1<<SPPW){1'b0}} : cnt_reg + 1'b1;
            end
            if (pix_close) begin
                pix_hi_reg <= hi_n;
                pix_lo_reg <= lo_n;
                pix_last_reg <= wv;
                pix_mean_reg <= mean_w[DW-1:0];
                pix_rms_reg <= rms_w[DW-1:0];
            end
        end
    end

    // Sweep sequencing: continuous repeats, a start command runs count sweeps (one when count is zero) then idles
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            sw_reg <= SW_IDLE;
            single_reg <= 1'b0;
            idx_reg <= 15'h0000;
        end else begin
            if (restart) begin
                idx_reg <= 15'h0000;
            end else if (first && (count_reg == 0 || idx_reg < count_reg) && idx_reg < MAX_COUNT) begin
                idx_reg <= idx_reg + 15'h0001;
            end
            if (wr_start) begin
                single_reg <= 1'b1;
            end else if (sweep_end && !cont_reg && (idx_reg >= count_reg)) begin
                single_reg <= 1'b0;
            end
            case (sw_reg)
                SW_IDLE: begin
                    if (wr_start || cont_reg) begin
                        sw_reg <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    if (first) begin
                        sw_reg <= SW_RUN;
                    end else if (!cont_reg && !single_reg && !wr_start) begin
                        sw_reg <= SW_IDLE;
                    end
                end
                SW_RUN: begin
                    if (sweep_end) begin
                        if (!cont_reg && idx_reg >= count_reg && !wr_start) begin
                            sw_reg <= SW_IDLE;
                        end else begin
                            sw_reg <= SW_WAIT;
                        end
                    end
                end
                default: sw_reg <= SW_IDLE;
            endcase
        end
    end

    // Registers and per-trace flags; a restart or mode change wins over a sweep event in the same cycle
    integer t;
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            for (t = 0; t < 3; t = t + 1) begin
                mode_reg[t] <= (t == 0) ? `TPA_MODE_WRITE : `TPA_MODE_BLANK;
                det_reg[t] <= `TPA_DET_AUTO;
            end
            fresh_reg <= 3'b111;
            arm_reg <= 3'b000;
            mism_reg <= 3'b000;
            count_reg <= 15'h0000;
            cont_reg <= 1'b0;
            scale_reg <= 1'b0;
            inhibit_reg <= 1'b0;
            spp_reg <= {SPPW{1'b0}};
            ref_reg <= {DW{1'b0}};
            gain_reg <= `TPA_GAIN_RESET;
        end else begin
            if (wr_cfg) begin
                count_reg <= new_cnt;
                cont_reg <= pwdata_i[`TPA_CFG_CONT];
                scale_reg <= pwdata_i[`TPA_CFG_SCALE];
                inhibit_reg <= pwdata_i[`TPA_CFG_INHIBIT];
                spp_reg <= pwdata_i[`TPA_CFG_SPP_MSB:`TPA_CFG_SPP_LSB];
            end
            if (wr_dsp) begin
                ref_reg <= pwdata_i[`TPA_DSP_REF_MSB:0];
                gain_reg <= pwdata_i[`TPA_DSP_GAIN_MSB:`TPA_DSP_GAIN_LSB];
            end
            for (t = 0; t < 3; t = t + 1) begin
                if (wr_tr[t]) begin
                    det_reg[t] <= pwdata_i[`TPA_TR_DET_MSB:`TPA_TR_DET_LSB];
                    if (new_mode <= `TPA_MODE_BLANK) begin
                        mode_reg[t] <= new_mode;
                    end
                end
                if (first) begin
                    arm_reg[t] <= fresh_reg[t];
                end
                if (sweep_end && arm_reg[t]) begin
                    fresh_reg[t] <= 1'b0;
                end
                if (wr_tr[t] && new_mode != mode_reg[t] && new_mode <= `TPA_MODE_BLANK) begin
                    mism_reg[t] <= 1'b0;
                end
                if (restart || (wr_tr[t] && new_mode != mode_reg[t]) ||
                    (wr_cfg && !inhibit_reg && (mode_reg[t] == `TPA_MODE_PEAK || mode_reg[t] == `TPA_MODE_FLOOR))) begin
                    fresh_reg[t] <= 1'b1;
                    arm_reg[t] <= 1'b0;
                end
                if (mode_reg[t] == `TPA_MODE_FREEZE && (wr_cfg || wr_dsp || wr_start ||
                    (wr_tr != 3'b000 && !wr_tr[t]) || (wr_tr[t] && new_mode == `TPA_MODE_FREEZE))) begin
                    mism_reg[t] <= 1'b1;
                end
            end
        end
    end

    // APB read data is captured in the setup cycle and held through the access cycle
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            prdata_o <= 32'h00000000;
        end else if (setup) begin
            case (paddr_i)
                `TPA_OFF_TRACE0: prdata_o <= {25'h0, det_reg[0], 1'b0, mode_reg[0]};
                `TPA_OFF_TRACE1: prdata_o <= {25'h0, det_reg[1], 1'b0, mode_reg[1]};
                `TPA_OFF_TRACE2: prdata_o <= {25'h0, det_reg[2], 1'b0, mode_reg[2]};
                `TPA_OFF_CFG: prdata_o <= {9'h0, spp_reg, 1'b0, inhibit_reg, scale_reg, cont_reg, 1'b0, count_reg};
                `TPA_OFF_STATUS: prdata_o <= {9'h0, count_reg[14:12], mism_reg, sweep_busy_o, 1'b0, idx_reg};
                `TPA_OFF_DISPLAY: prdata_o <= {8'h0, gain_reg, ref_reg};
                default: prdata_o <= 32'h00000000;
            endcase
        end
    end

    // Reader port, one cycle latency
    wire [31:0] raddr_w = rd_trace_i * PIXELS + rd_pix_i;
    wire [AW-1:0] raddr = raddr_w[AW-1:0];
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_valid_o <= 1'b0;
            rd_hi_o <= {DW{1'b0}};
            rd_lo_o <= {DW{1'b0}};
        end else begin
            rd_valid_o <= rd_en_i & (rd_trace_i != 2'd3) & (rd_pix_i < PIXELS) &
                          (mode_reg[rd_trace_i] != `TPA_MODE_BLANK);
            if (rd_en_i && rd_trace_i != 2'd3 && rd_pix_i < PIXELS) begin
                rd_hi_o <= dmap(mem_hi[raddr], ref_reg, gain_reg);
                rd_lo_o <= dmap(mem_lo[raddr], ref_reg, gain_reg);
            end
        end
    end
endmodule // tpa_trace_accumulator

/* File: hdl/tpa_defs.vh */
// Constants for the trace pixel accumulator: register map, field layout, codes, reset values.
// Assumes it is included by its bare name from the design file.
`ifndef TPA_DEFS_VH
`define TPA_DEFS_VH
`define TPA_OFF_TRACE0 8'h00
`define TPA_OFF_TRACE1 8'h04
`define TPA_OFF_TRACE2 8'h08
`define TPA_OFF_CFG 8'h0C
`define TPA_OFF_CMD 8'h10
`define TPA_OFF_STATUS 8'h14
`define TPA_OFF_DISPLAY 8'h18
`define TPA_TR_MODE_MSB 2
`define TPA_TR_MODE_LSB 0
`define TPA_TR_DET_MSB 6
`define TPA_TR_DET_LSB 4
`define TPA_CFG_CNT_MSB 14
`define TPA_CFG_CNT_LSB 0
`define TPA_CFG_CONT 16
`define TPA_CFG_SCALE 17
`define TPA_CFG_INHIBIT 18
`define TPA_CFG_SPP_MSB 22
`define TPA_CFG_SPP_LSB 20
`define TPA_CMD_START 0
`define TPA_ST_IDX_MSB 14
`define TPA_ST_RUN 16
`define TPA_ST_MISM_LSB 17
`define TPA_DSP_REF_MSB 15
`define TPA_DSP_GAIN_LSB 16
`define TPA_DSP_GAIN_MSB 23
`define TPA_MODE_WRITE 3'h0
`define TPA_MODE_PEAK 3'h1
`define TPA_MODE_FLOOR 3'h2
`define TPA_MODE_AVG 3'h3
`define TPA_MODE_FREEZE 3'h4
`define TPA_MODE_BLANK 3'h5
`define TPA_DET_AUTO 3'h0
`define TPA_DET_UPPER 3'h1
`define TPA_DET_LOWER 3'h2
`define TPA_DET_INSTANT 3'h3
`define TPA_DET_RMS 3'h4
`define TPA_DET_MEAN 3'h5
`define TPA_DET_DUAL 3'h6
`define TPA_RUN_WEIGHT 16'h000A
`define TPA_GAIN_RESET 8'h40
`define TPA_GAIN_SHIFT 6
`endif

/* File: sim/tpa_props.sv */
// Port checker for the trace pixel accumulator.
// Assumes binding to the accumulator top; one clock, synchronous low reset.
`timescale 1ns/1ps
module tpa_props #(parameter DW = 16) (
    input wire clk_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [7:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire smp_valid_i,
    input wire smp_ready_o,
    input wire smp_sweep_start_i,
    input wire [DW-1:0] smp_level_i,
    input wire [DW-1:0] smp_pow_i,
    input wire rd_en_i,
    input wire [1:0] rd_trace_i,
    input wire [9:0] rd_pix_i,
    input wire rd_valid_o,
    input wire [DW-1:0] rd_hi_o,
    input wire [DW-1:0] rd_lo_o,
    input wire sweep_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // One closed pixel costs three write cycles, one per trace
    sequence s_pix_write;
        !smp_ready_o [*3] ##1 smp_ready_o;
    endsequence
    sequence s_start_wr;
        psel_i && penable_i && pwrite_i && paddr_i == 8'h10 && pwdata_i[0];
    endsequence
    chk_pixel_gap: assert property ($fell(smp_ready_o) |-> s_pix_write)
        else $error("ready gap not three cycles");
    chk_pix_range: assert property (rd_en_i && rd_pix_i >= 10'd625 |=> !rd_valid_o)
        else $error("pixel beyond range read valid");
    chk_trace_none: assert property (rd_en_i && rd_trace_i == 2'h3 |=> !rd_valid_o)
        else $error("trace three read valid");
    chk_reset_state: assert property ($rose(resetn_i) |-> prdata_o == 32'h0 && !rd_valid_o && smp_ready_o && !sweep_busy_o)
        else $error("outputs not at reset state");
    chk_start_busy: assert property (s_start_wr |=> sweep_busy_o)
        else $error("start did not raise busy");
    chk_idle_quiet: assert property (!sweep_busy_o && smp_ready_o |=> smp_ready_o)
        else $error("pixel closed while idle");
    chk_err_access: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("error outside access");
    chk_err_unmapped: assert property (psel_i && penable_i && paddr_i > 8'h18 |-> pslverr_o)
        else $error("unmapped access without error");
endmodule // tpa_props

/* File: sim/tpa_sweep_src.sv */
// Sample source model: one sweep of 625 samples per go pulse.
// Assumes one sample per pixel and a ready that only moves after rising edges.
`timescale 1ns/1ps
module tpa_sweep_src (
    input wire clk_i,
    input wire go_i,
    input wire [15:0] lvl_i,
    input wire smp_ready_i,
    output logic smp_valid_o,
    output logic smp_sweep_start_o,
    output logic [15:0] smp_level_o,
    output logic [15:0] smp_pow_o,
    output logic busy_o
);
    int i;
    initial begin
        smp_valid_o = 1'b0;
        smp_sweep_start_o = 1'b0;
        smp_level_o = 16'hFFFF;
        smp_pow_o = 16'hFFFF;
        busy_o = 1'b0;
    end
    always begin
        @(posedge clk_i);
        if (go_i) begin
            for (i = 0; i < 625; i++) begin
                busy_o <= 1'b1;
                smp_valid_o <= 1'b1;
                smp_sweep_start_o <= (i == 0);
                smp_level_o <= lvl_i + 16'(i);
                smp_pow_o <= lvl_i + 16'(i);
                do @(posedge clk_i); while (!smp_ready_i);
            end
            smp_valid_o <= 1'b0;
            smp_sweep_start_o <= 1'b0;
            // Released lines flip so stale data never looks valid
            smp_level_o <= ~smp_level_o;
            smp_pow_o <= ~smp_pow_o;
            busy_o <= 1'b0;
        end
    end
endmodule // tpa_sweep_src

/* File: sim/trace_pixel_accumulator_test.sv */
// Self-checking bench for the trace pixel accumulator.
// Assumes the sample source model and the bound port checker.
`timescale 1ns/1ps
module trace_pixel_accumulator_test;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rd_en = 1'b0, go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, sv, ss, sr, rdv, busy, sbusy;
    logic [15:0] slev, spow, rhi, rlo, lvl = 16'h0;
    logic [1:0] rtr = 2'h0;
    logic [9:0] rpix = 10'h0;
    int miscompares = 0, check_count = 0;
    always #2.5 clk = ~clk;
    tpa_trace_accumulator dut (.clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .smp_valid_i(sv), .smp_ready_o(sr), .smp_sweep_start_i(ss), .smp_level_i(slev), .smp_pow_i(spow),
        .rd_en_i(rd_en), .rd_trace_i(rtr), .rd_pix_i(rpix), .rd_valid_o(rdv), .rd_hi_o(rhi), .rd_lo_o(rlo),
        .sweep_busy_o(busy));
    tpa_sweep_src src (.clk_i(clk), .go_i(go), .lvl_i(lvl), .smp_ready_i(sr), .smp_valid_o(sv),
        .smp_sweep_start_o(ss), .smp_level_o(slev), .smp_pow_o(spow), .busy_o(sbusy));
    task tally_and_finish;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task hang;
        miscompares++;
        $display("Error wait expected done seen timeout");
        tally_and_finish;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) hang;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rd(input logic [1:0] t, input logic [9:0] p);
        @(posedge clk);
        rd_en <= 1'b1;
        rtr <= t;
        rpix <= p;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
    endtask
    task sweep(input logic [15:0] v);
        int n;
        @(posedge clk);
        go <= 1'b1;
        lvl <= v;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sbusy && n < 5000);
        if (n >= 5000) hang;
        repeat (6) @(posedge clk);
    endtask
    task t_reset;
        apb(0, 8'h00, 0); check("trace0", rdat, 32'h0);
        apb(0, 8'h04, 0); check("trace1", rdat, 32'h5);
        apb(0, 8'h08, 0); check("trace2", rdat, 32'h5);
        apb(0, 8'h0C, 0); check("cfg", rdat, 32'h0);
        apb(0, 8'h14, 0); check("status", rdat, 32'h0);
        apb(1, 8'h00, 32'h7); apb(0, 8'h00, 0); check("bad mode", rdat, 32'h0);
        apb(1, 8'h0C, 32'hFFFF); apb(0, 8'h0C, 0); check("count clamp", rdat, 32'd30000);
        apb(0, 8'h20, 0); check("unmapped", {31'h0, rerr}, 32'h1);
        $display("t_reset done");
    endtask
    task t_write;
        apb(1, 8'h0C, 0); apb(1, 8'h10, 1); sweep(16'd100);
        check("busy", {31'h0, busy}, 0);
        rd(0, 0); check("valid", {31'h0, rdv}, 1);
        check("hi", {16'h0, rhi}, 100);
        check("lo", {16'h0, rlo}, 100);
        rd(0, 624); check("last pixel", {16'h0, rhi}, 724);
        rd(1, 0); check("blank", {31'h0, rdv}, 0);
        rd(3, 0); rd(0, 625); check("range", {31'h0, rdv}, 0);
        // No start given: samples must be dropped
        sweep(16'd900); rd(0, 0); check("idle", {16'h0, rhi}, 100);
        $display("t_write done");
    endtask
    task t_hold(input logic [31:0] mode, input logic [31:0] cfg, input logic [15:0] exp);
        apb(1, 8'h00, mode); apb(1, 8'h0C, cfg); apb(1, 8'h10, 1); sweep(16'd300); sweep(16'd50);
        apb(0, 8'h14, 0); check("index", {17'h0, rdat[14:0]}, {17'h0, cfg[14:0]});
        rd(0, 0); check("hold", {16'h0, rhi}, {16'h0, exp});
        $display("t_hold done");
    endtask
    task t_avg;
        apb(1, 8'h00, 32'h43); apb(1, 8'h0C, 2); apb(1, 8'h10, 1); sweep(16'd100); sweep(16'd200);
        rd(0, 0); check("avg two", {16'h0, rhi}, 150);
        rd(0, 624); check("avg last", {16'h0, rhi}, 774);
        apb(1, 8'h0C, 32'h10002); apb(1, 8'h10, 1); sweep(16'd100); sweep(16'd200); sweep(16'd300);
        rd(0, 0); check("avg run", {16'h0, rhi}, 225);
        apb(0, 8'h14, 0); check("avg index", {17'h0, rdat[14:0]}, 2);
        apb(1, 8'h0C, 32'h10000); apb(1, 8'h10, 1); sweep(16'd100); sweep(16'd200);
        rd(0, 0); check("avg ten", {16'h0, rhi}, 110);
        $display("t_avg done");
    endtask
    task t_freeze;
        apb(1, 8'h0C, 0); apb(1, 8'h00, 4);
        apb(0, 8'h14, 0); check("no mismatch", {31'h0, rdat[17]}, 0);
        apb(1, 8'h18, 32'h0040000A);
        apb(0, 8'h14, 0); check("mismatch", {31'h0, rdat[17]}, 1);
        rd(0, 0); check("rescaled", {16'h0, rhi}, 100);
        apb(1, 8'h10, 1); sweep(16'd7);
        rd(0, 0); check("frozen", {16'h0, rhi}, 100);
        check("frozen shown", {31'h0, rdv}, 1);
        $display("t_freeze done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_write;
        t_hold(1, 32'h2, 16'd300);
        t_hold(2, 32'h2, 16'd50);
        t_hold(1, 32'h10001, 16'd50);
        t_avg;
        t_freeze;
        tally_and_finish;
    end
endmodule // trace_pixel_accumulator_test
bind tpa_trace_accumulator tpa_props #(.DW(DW)) u_props (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o),
    .smp_sweep_start_i(smp_sweep_start_i), .smp_level_i(smp_level_i), .smp_pow_i(smp_pow_i), .rd_en_i(rd_en_i),
    .rd_trace_i(rd_trace_i), .rd_pix_i(rd_pix_i), .rd_valid_o(rd_valid_o), .rd_hi_o(rd_hi_o), .rd_lo_o(rd_lo_o),
    .sweep_busy_o(sweep_busy_o));
